// *** hw/brla_pkg.sv ***
// Constants, types and register map of the line activation block.
package brla_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TN_TIME_MS = 9;
  localparam int TN_CYC = TN_TIME_MS * (CLK_HZ / 1000);
  localparam int TN_CNT_W = 19;
  localparam int ACT_HOLD_MF = 3;
  localparam int HOLD_W = 2;
  localparam int TC_W = 24;
  localparam logic [23:0] M4_TC_RST = 24'h00ffff;
  localparam logic [23:0] M6_TC_RST = 24'h00ffff;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h04;
  localparam logic [4:0] REG_IRQ_ST = 5'h08;
  localparam logic [4:0] REG_IRQ_CLR = 5'h0c;
  localparam logic [4:0] REG_IRQ_EN = 5'h10;
  localparam logic [4:0] REG_M4_TC = 5'h14;
  localparam logic [4:0] REG_M6_TC = 5'h18;

  localparam int CTRL_W = 2;
  localparam int CTRL_L2RDY = 0;
  localparam int CTRL_ECTRAIN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  localparam int IRQ_W = 5;
  localparam int IRQ_TR_ON = 0;
  localparam int IRQ_TR_OFF = 1;
  localparam int IRQ_M4 = 2;
  localparam int IRQ_M6 = 3;
  localparam int IRQ_NT_ACT = 4;
  localparam logic [4:0] IRQ_RST = 5'h00;

  localparam int ST_STATE_LSB = 0;
  localparam int ST_FULLOP = 4;
  localparam int ST_LT_TR = 5;
  localparam int ST_LT_ACT = 6;
  localparam int ST_NT_TR = 7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    NT_S0, NT_S1, NT_S2, NT_S3, NT_S4, NT_S5, NT_S6, NT_S7, NT_S8,
    NT_S9, NT_S10, NT_S11, NT_S12, NT_S7A, NT_S11A
  } brla_nt_st_t;

  typedef enum logic [2:0] {
    SIG_SN0, SIG_SN1, SIG_SN2, SIG_SN3, SIG_TN
  } brla_line_sig_t;

  typedef enum logic [1:0] {INFO_0, INFO_2, INFO_4} brla_info_t;

endpackage

// *** hw/brla_ifs.sv ***
// Interfaces joining the main block to its two timers and ACT holder.
`timescale 1ns/1ps
interface brla_tmr_if;
  logic start;
  logic stop;
  logic [brla_pkg::TC_W-1:0] tc;
  logic expired;
  modport ctl(output start, output stop, output tc, input expired);
  modport tmr(input start, input stop, input tc, output expired);
endinterface

interface brla_act_if;
  logic want;
  logic mf_start;
  logic act;
  modport ctl(output want, output mf_start, input act);
  modport hold(input want, input mf_start, output act);
endinterface

// *** hw/brla_timer.sv ***
// Start/stop timer with a programmable terminal count.
`timescale 1ns/1ps
module brla_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  brla_tmr_if.tmr t
);
  import brla_pkg::*;

  logic run_q, run_d;
  logic [TC_W-1:0] cnt_q, cnt_d;
  logic exp_q, exp_d;

  always_comb begin
    run_d = run_q;
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (t.stop) begin
      run_d = 1'b0;
    end else if (t.start) begin
      run_d = 1'b1;
      cnt_d = '0;
    end else if (run_q) begin
      if (cnt_q >= t.tc) begin
        run_d = 1'b0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign t.expired = exp_q;
endmodule

// *** hw/brla_act_hold.sv ***
// Transmitted ACT bit that changes on multiframe starts and then holds.
`timescale 1ns/1ps
module brla_act_hold (
  input wire logic i_clk,
  input wire logic i_rst_n,
  brla_act_if.hold a
);
  import brla_pkg::*;

  logic act_q, act_d;
  logic [HOLD_W-1:0] hold_q, hold_d;

  // A new value is kept for three multiframes before another change.
  always_comb begin
    act_d = act_q;
    hold_d = hold_q;
    if (a.mf_start) begin
      if (hold_q != '0) begin
        hold_d = hold_q - 1'b1;
      end else if (a.want != act_q) begin
        act_d = a.want;
        hold_d = HOLD_W'(ACT_HOLD_MF - 1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      act_q <= 1'b0;
      hold_q <= '0;
    end else begin
      act_q <= act_d;
      hold_q <= hold_d;
    end
  end

  assign a.act = act_q;
endmodule

// *** hw/brla_top.sv ***
// Line activation: transparency control, ACT signalling, state machine.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps

module brla_top #(
  parameter int TN_CYCLES = brla_pkg::TN_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [brla_pkg::ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_irq,
  input wire logic i_sf_start,
  input wire logic i_mf_start,
  input wire logic i_bit_lock,
  input wire logic i_frame_sync,
  input wire logic i_mf_marker,
  input wire logic i_ec_conv,
  input wire logic i_eq_conv,
  input wire logic i_rx_act,
  input wire logic i_rx_dea,
  input wire logic i_bd_slot,
  input wire logic i_net_bd,
  input wire logic i_line_bd,
  output logic o_line_bd,
  output logic o_net_bd,
  output logic o_lt_act,
  input wire logic i_power,
  input wire logic i_rx_info1,
  input wire logic i_rx_info3,
  input wire logic i_rx_tl,
  input wire logic i_fw_sync,
  input wire logic i_ifw_sync,
  output brla_pkg::brla_line_sig_t o_nt_line_sig,
  output logic o_nt_line_act,
  output brla_pkg::brla_info_t o_nt_te_info,
  output logic o_nt_transp
);
  import brla_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d, irq_ev;
  logic [TC_W-1:0] m4_tc_q, m4_tc_d, m6_tc_q, m6_tc_d;
  logic wait_q, wait_d, irq_q, irq_d;
  logic [31:0] rdata_q, rdata_d;
  logic acc;
  logic full_op, tr_cond;
  logic tr_q, tr_d;
  logic line_bd_q, line_bd_d, net_bd_q, net_bd_d;
  brla_nt_st_t st_q, st_d;
  logic [TN_CNT_W-1:0] tn_q, tn_d;
  brla_line_sig_t sig_q, sig_d;
  logic nact_q, nact_d, ntr_q, ntr_d;
  brla_info_t info_q, info_d;
  logic m4_start, m4_stop, m6_stop;

  brla_tmr_if m4_if();
  brla_tmr_if m6_if();
  brla_act_if act_if();

  brla_timer u_m4 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .t(m4_if)
  );

  brla_timer u_m6 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .t(m6_if)
  );

  brla_act_hold u_act (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .a(act_if)
  );

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  assign m4_if.start = m4_start;
  assign m4_if.stop = m4_stop;
  assign m4_if.tc = m4_tc_q;
  assign m6_if.start = 1'b0;
  assign m6_if.stop = m6_stop;
  assign m6_if.tc = m6_tc_q;

  // ---------------------------------------------------------------
  // Transparency at the line termination end
  // ---------------------------------------------------------------
  assign full_op = i_bit_lock & i_frame_sync & i_mf_marker
                 & i_ec_conv & i_eq_conv;
  assign tr_cond = full_op & i_mf_marker & i_rx_act;

  assign act_if.want = tr_cond & ctrl_q[CTRL_L2RDY];
  assign act_if.mf_start = i_mf_start;

  always_comb begin
    tr_d = tr_q;
    if (!tr_cond) begin
      tr_d = 1'b0;
    end else if (i_sf_start && act_if.act) begin
      tr_d = 1'b1;
    end
    // Both directions use the same switch instant.
    line_bd_d = tr_d & i_bd_slot & i_net_bd;
    net_bd_d = tr_d & i_bd_slot & i_line_bd;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tr_q <= 1'b0;
      line_bd_q <= 1'b0;
      net_bd_q <= 1'b0;
    end else begin
      tr_q <= tr_d;
      line_bd_q <= line_bd_d;
      net_bd_q <= net_bd_d;
    end
  end

  // ---------------------------------------------------------------
  // Network termination state machine
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    tn_d = tn_q;
    m4_start = 1'b0;
    m4_stop = 1'b0;
    m6_stop = 1'b0;
    if (!i_power) begin
      st_d = NT_S0;
    end else begin
      unique case (st_q)
        NT_S0: begin
          st_d = NT_S2;
          m4_start = 1'b1;
        end
        NT_S1: begin
          if (i_rx_info1 || i_rx_tl) begin
            st_d = NT_S2;
            m4_start = 1'b1;
          end
        end
        NT_S2: begin
          if (tn_q >= TN_CNT_W'(TN_CYCLES - 1)) begin
            st_d = ctrl_q[CTRL_ECTRAIN] ? NT_S3 : NT_S4;
          end
        end
        NT_S3: begin
          if (i_ec_conv) begin
            st_d = NT_S4;
          end
        end
        NT_S4: begin
          if (i_fw_sync) begin
            st_d = NT_S5;
          end
        end
        NT_S5: begin
          if (i_ifw_sync) begin
            st_d = NT_S6;
            m4_stop = 1'b1;
          end
        end
        NT_S6, NT_S11: begin
          if (i_rx_info3) begin
            st_d = NT_S7;
          end
        end
        NT_S11A: begin
          if (i_rx_info3) begin
            st_d = NT_S7A;
          end
        end
        NT_S7: begin
          if (!i_rx_info3) begin
            st_d = NT_S11;
          end else if (i_rx_act && i_rx_dea) begin
            st_d = NT_S8;
          end
        end
        NT_S8: begin
          if (!i_rx_info3) begin
            st_d = NT_S11;
          end
        end
        NT_S7A: begin
          if (!i_rx_info3) begin
            st_d = NT_S11A;
          end
        end
        NT_S12: begin
          if (i_rx_tl) begin
            st_d = NT_S2;
            m4_start = 1'b1;
            m6_stop = 1'b1;
          end
        end
        NT_S9, NT_S10: begin
          st_d = st_q;
        end
      endcase
    end
    tn_d = (st_d == NT_S2 && st_q == NT_S2) ? tn_q + 1'b1 : '0;
  end

  // Outputs of each state toward the line and the terminal.
  always_comb begin
    sig_d = SIG_SN0;
    nact_d = 1'b0;
    info_d = INFO_0;
    unique case (st_d)
      NT_S2: sig_d = SIG_TN;
      NT_S3: sig_d = SIG_SN1;
      NT_S5: sig_d = SIG_SN2;
      NT_S6, NT_S11: begin
        sig_d = SIG_SN3;
        info_d = INFO_2;
      end
      NT_S7, NT_S11A: begin
        sig_d = SIG_SN3;
        nact_d = 1'b1;
        info_d = INFO_2;
      end
      NT_S8, NT_S7A: begin
        sig_d = SIG_SN3;
        nact_d = 1'b1;
        info_d = INFO_4;
      end
      NT_S9: sig_d = SIG_SN3;
      NT_S0, NT_S1, NT_S4, NT_S10, NT_S12: sig_d = SIG_SN0;
    endcase
    ntr_d = full_op & i_rx_act & i_rx_dea
          & (st_d == NT_S8 || st_d == NT_S7A);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q <= NT_S1;
      tn_q <= '0;
      sig_q <= SIG_SN0;
      nact_q <= 1'b0;
      info_q <= INFO_0;
      ntr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tn_q <= tn_d;
      sig_q <= sig_d;
      nact_q <= nact_d;
      info_q <= info_d;
      ntr_q <= ntr_d;
    end
  end

  // ---------------------------------------------------------------
  // Register slave and interrupt
  // ---------------------------------------------------------------
  assign acc = (i_read | i_write) & ~wait_q;
  assign irq_ev[IRQ_TR_ON] = tr_d & ~tr_q;
  assign irq_ev[IRQ_TR_OFF] = ~tr_d & tr_q;
  assign irq_ev[IRQ_M4] = m4_if.expired;
  assign irq_ev[IRQ_M6] = m6_if.expired;
  assign irq_ev[IRQ_NT_ACT] = (st_d == NT_S8) & (st_q != NT_S8);

  always_comb begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    m4_tc_d = m4_tc_q;
    m6_tc_d = m6_tc_q;
    irq_st_d = irq_st_q;
    rdata_d = rdata_q;
    wait_d = ~((i_read | i_write) & wait_q);
    if (acc && i_write) begin
      unique case (i_address)
        REG_CTRL: ctrl_d = i_writedata[CTRL_W-1:0];
        REG_IRQ_CLR: irq_st_d = irq_st_q & ~i_writedata[IRQ_W-1:0];
        REG_IRQ_EN: irq_en_d = i_writedata[IRQ_W-1:0];
        REG_M4_TC: m4_tc_d = i_writedata[TC_W-1:0];
        REG_M6_TC: m6_tc_d = i_writedata[TC_W-1:0];
        default: rdata_d = rdata_q;
      endcase
    end
    // Events win over a clear in the same cycle.
    irq_st_d = irq_st_d | irq_ev;
    if (i_read && wait_q) begin
      rdata_d = '0;
      unique case (i_address)
        REG_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
        REG_STAT: begin
          rdata_d[ST_STATE_LSB +: 4] = st_q;
          rdata_d[ST_FULLOP] = full_op;
          rdata_d[ST_LT_TR] = tr_q;
          rdata_d[ST_LT_ACT] = act_if.act;
          rdata_d[ST_NT_TR] = ntr_q;
        end
        REG_IRQ_ST: rdata_d[IRQ_W-1:0] = irq_st_q;
        REG_IRQ_EN: rdata_d[IRQ_W-1:0] = irq_en_q;
        REG_M4_TC: rdata_d[TC_W-1:0] = m4_tc_q;
        REG_M6_TC: rdata_d[TC_W-1:0] = m6_tc_q;
        default: rdata_d = '0;
      endcase
    end
    irq_d = |(irq_st_d & irq_en_d);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RST;
      irq_st_q <= IRQ_RST;
      irq_en_q <= IRQ_RST;
      m4_tc_q <= M4_TC_RST;
      m6_tc_q <= M6_TC_RST;
      wait_q <= 1'b1;
      rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_st_q <= irq_st_d;
      irq_en_q <= irq_en_d;
      m4_tc_q <= m4_tc_d;
      m6_tc_q <= m6_tc_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_irq = irq_q;
  assign o_line_bd = line_bd_q;
  assign o_net_bd = net_bd_q;
  assign o_lt_act = act_if.act;
  assign o_nt_line_sig = sig_q;
  assign o_nt_line_act = nact_q;
  assign o_nt_te_info = info_q;
  assign o_nt_transp = ntr_q;
endmodule

// *** test/brla_checker.sv ***
// Port assertions of the line activation block.
`timescale 1ns/1ps
module brla_checker
  import brla_pkg::*;
#(
  parameter int TN_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_mf_start,
  input wire logic i_bit_lock,
  input wire logic i_frame_sync,
  input wire logic i_mf_marker,
  input wire logic i_ec_conv,
  input wire logic i_eq_conv,
  input wire logic i_rx_act,
  input wire logic i_bd_slot,
  input wire logic o_line_bd,
  input wire logic o_lt_act,
  input wire logic i_power,
  input brla_pkg::brla_line_sig_t o_nt_line_sig,
  input wire logic o_nt_line_act,
  input brla_pkg::brla_info_t o_nt_te_info,
  input wire logic o_nt_transp
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic tr;
  logic ap_q;
  logic [1:0] hc_q, hc_d;
  int tc_q, tc_d;
  assign tr = i_bit_lock & i_frame_sync & i_mf_marker & i_ec_conv
    & i_eq_conv & i_rx_act;
  always_comb begin
    hc_d = hc_q;
    if (o_lt_act != ap_q) begin
      hc_d = 2'h0;
    end else if (i_mf_start && hc_q != 2'h3) begin
      hc_d = hc_q + 2'h1;
    end
    tc_d = (o_nt_line_sig == SIG_TN) ? tc_q + 1 : 0;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hc_q <= 2'h3;
      ap_q <= 1'h0;
      tc_q <= 0;
    end else begin
      hc_q <= hc_d;
      ap_q <= o_lt_act;
      tc_q <= tc_d;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_hold;
    (o_lt_act != ap_q) |-> hc_q == 2'h3 && $past(i_mf_start);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Sent ACT changed too early.");
  property p_bd;
    o_line_bd |-> $past(i_bd_slot) && ($past(tr) || $past(tr, 2));
  endproperty
  a_bd: assert property (p_bd)
    else $error("Channel bit passed without conditions.");
  property p_pwr;
    !i_power |=> o_nt_line_sig == SIG_SN0 && o_nt_te_info == INFO_0;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("Power loss did not reset the state.");
  property p_tn;
    $past(o_nt_line_sig) == SIG_TN && o_nt_line_sig != SIG_TN
      && $past(i_power) |-> tc_q inside {[TN_CYCLES-1:TN_CYCLES+1]};
  endproperty
  a_tn: assert property (p_tn)
    else $error("Tone length wrong.");
  property p_sig0;
    o_nt_line_sig != SIG_SN3 |->
      o_nt_te_info == INFO_0 && !o_nt_line_act && !o_nt_transp;
  endproperty
  a_sig0: assert property (p_sig0)
    else $error("Terminal signal wrong for line signal.");
  property p_info4;
    o_nt_te_info == INFO_4 |-> o_nt_line_act && o_nt_line_sig == SIG_SN3;
  endproperty
  a_info4: assert property (p_info4)
    else $error("Line signal wrong in active state.");
  property p_info2;
    o_nt_te_info == INFO_2 |-> o_nt_line_sig == SIG_SN3 && !o_nt_transp;
  endproperty
  a_info2: assert property (p_info2)
    else $error("Line signal wrong in sync state.");
  property p_ntt;
    o_nt_transp |-> $past(i_rx_act) && o_nt_te_info == INFO_4;
  endproperty
  a_ntt: assert property (p_ntt)
    else $error("Terminal side transparent too early.");
  c_lt: cover property (o_lt_act && o_line_bd);
  c_nt: cover property (o_nt_transp);
  c_tn: cover property (o_nt_line_sig == SIG_TN);
endmodule

// *** test/brla_far_end.sv ***
// Far-end transceiver: framing, payload and its own sent ACT bit.
`timescale 1ns/1ps
module brla_far_end (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ready,
  output logic o_sf_start,
  output logic o_mf_start,
  output logic o_rx_act,
  output logic o_bd_slot,
  output logic o_pay
);
  logic [4:0] pos_q, pos_d;
  logic act_q, act_d;
  logic [1:0] hold_q, hold_d;
  always_comb begin
    pos_d = pos_q + 5'h01;
    act_d = act_q;
    hold_d = hold_q;
    if (pos_q == 5'h1f && hold_q != 2'h0) begin
      hold_d = hold_q - 2'h1;
    end
    if (pos_q == 5'h1f && hold_q == 2'h0 && act_q != i_ready) begin
      act_d = i_ready;
      hold_d = 2'h2;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pos_q <= 5'h00;
      act_q <= 1'h0;
      hold_q <= 2'h0;
    end else begin
      pos_q <= pos_d;
      act_q <= act_d;
      hold_q <= hold_d;
    end
  end
  assign o_sf_start = pos_q[2:0] == 3'h0;
  assign o_mf_start = pos_q == 5'h00;
  assign o_rx_act = act_q;
  assign o_bd_slot = pos_q[0];
  assign o_pay = pos_q[1] ^ pos_q[3];
endmodule

// *** test/brla_top_tb.sv ***
// Self-checking bench of the line activation block.
`timescale 1ns/1ps
module brla_top_tb;
  import brla_pkg::*;
  localparam int TNC = 20;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_read = 1'h0, i_write = 1'h0;
  logic [4:0] i_address = 5'h00;
  logic [31:0] i_writedata = 32'h0, rd, o_readdata;
  logic up = 1'h0, i_ec_conv = 1'h0, i_eq_conv = 1'h0, i_rx_dea = 1'h1;
  logic i_power = 1'h1, i_rx_info1 = 1'h0, i_rx_info3 = 1'h0;
  logic i_rx_tl = 1'h0, i_fw_sync = 1'h0, i_ifw_sync = 1'h0, rdy = 1'h0;
  logic i_line_bd = 1'h0, sf, mf, rx_act, slot, pay, o_line_bd, o_net_bd;
  logic o_lt_act, o_irq, o_waitrequest, o_nt_line_act, o_nt_transp;
  logic [1:0] el;
  brla_line_sig_t o_nt_line_sig;
  brla_info_t o_nt_te_info;
  int miscompares = 0, checks = 0, n, k, t0, cyc = 0;
  brla_far_end u_far (.i_clk, .i_rst_n, .i_ready(rdy), .o_sf_start(sf),
    .o_mf_start(mf), .o_rx_act(rx_act), .o_bd_slot(slot), .o_pay(pay));
  brla_top #(.TN_CYCLES(TNC)) uut (.i_clk, .i_rst_n, .i_address, .i_read,
    .i_write, .i_writedata, .o_readdata, .o_waitrequest, .o_irq,
    .i_sf_start(sf), .i_mf_start(mf), .i_bit_lock(up), .i_frame_sync(up),
    .i_mf_marker(up), .i_ec_conv, .i_eq_conv, .i_rx_act(rx_act), .i_rx_dea,
    .i_bd_slot(slot), .i_net_bd(pay), .i_line_bd, .o_line_bd, .o_net_bd,
    .o_lt_act, .i_power, .i_rx_info1, .i_rx_info3, .i_rx_tl, .i_fw_sync,
    .i_ifw_sync, .o_nt_line_sig, .o_nt_line_act, .o_nt_te_info, .o_nt_transp);
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  function automatic logic [1:0] bd_exp(input logic s, a, b);
    return {s & a, s & b};
  endfunction
  function automatic logic [6:0] nt_exp(input brla_line_sig_t s,
    input logic a, input brla_info_t f, input logic t);
    return {s, a, f, t};
  endfunction
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= !w;
    do @(posedge i_clk); while (o_waitrequest !== 1'h0);
    rd = o_readdata;
    i_write <= 1'h0;
    i_read <= 1'h0;
  endtask
  task automatic nt_step(input logic [4:0] v, input logic [6:0] e);
    {i_power, i_rx_info3, i_fw_sync, i_ifw_sync, rdy} <= v;
    n = 0;
    while (rx_act !== v[0] && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    repeat (3) @(posedge i_clk);
    chk(32'({o_nt_line_sig, o_nt_line_act, o_nt_te_info, o_nt_transp}),
      32'(e));
  endtask
  always @(posedge i_clk) begin
    i_line_bd <= 1'($urandom);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(18));
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'h1;
    bus(1'h0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, 5'h1c, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, REG_IRQ_EN, 32'h1);
    bus(1'h1, REG_CTRL, 32'h1);
    up <= 1'h1;
    i_ec_conv <= 1'h1;
    rdy <= 1'h1;
    repeat (150) begin
      @(posedge i_clk);
      chk(32'({o_lt_act, o_line_bd, o_net_bd}), 32'h0);
    end
    i_eq_conv <= 1'h1;
    n = 0;
    while (o_lt_act !== 1'h1 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    t0 = cyc;
    chk(32'(o_lt_act), 32'h1);
    @(posedge sf);
    @(posedge i_clk);
    repeat (32) begin
      el = bd_exp(slot, pay, i_line_bd);
      @(posedge i_clk);
      chk(32'({o_line_bd, o_net_bd}), 32'(el));
    end
    chk(32'(o_irq), 32'h1);
    bus(1'h1, REG_IRQ_CLR, 32'h1f);
    bus(1'h0, REG_IRQ_ST, 32'h0);
    chk(rd & 32'h1, 32'h0);
    chk(32'(o_irq), 32'h0);
    bus(1'h1, REG_IRQ_EN, 32'h0);
    bus(1'h1, REG_CTRL, 32'h0);
    n = 0;
    while (o_lt_act !== 1'h0 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    chk(32'(o_lt_act), 32'h0);
    chk(32'(cyc - t0 >= 96), 32'h1);
    i_eq_conv <= 1'h0;
    repeat (4) @(posedge i_clk);
    chk(32'({o_irq, o_line_bd, o_net_bd}), 32'h0);
    bus(1'h0, REG_IRQ_ST, 32'h0);
    chk(rd & 32'h2, 32'h2);
    for (k = 0; k < 3; k++) begin
      i_power <= 1'(k != 0);
      i_rst_n <= 1'h0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'h1;
      bus(1'h1, REG_CTRL, (k == 1) ? 32'h2 : 32'h0);
      chk(32'(o_nt_line_sig), 32'(SIG_SN0));
      i_power <= 1'h1;
      i_rx_info1 <= 1'(k == 1);
      i_rx_tl <= 1'(k == 2);
      n = 0;
      while (o_nt_line_sig !== SIG_TN && n < 4) begin
        @(posedge i_clk);
        n++;
      end
      chk(32'(o_nt_line_sig), 32'(SIG_TN));
      n = 0;
      while (o_nt_line_sig === SIG_TN && n < 100) begin
        @(posedge i_clk);
        n++;
      end
      chk(32'(n), 32'(TNC));
      chk(32'(o_nt_line_sig), (k == 1) ? 32'h1 : 32'h0);
      i_rx_info1 <= 1'h0;
      i_rx_tl <= 1'h0;
    end
    i_eq_conv <= 1'h1;
    nt_step(5'h14, nt_exp(SIG_SN2, 1'h0, INFO_0, 1'h0));
    nt_step(5'h16, nt_exp(SIG_SN3, 1'h0, INFO_2, 1'h0));
    nt_step(5'h1e, nt_exp(SIG_SN3, 1'h1, INFO_2, 1'h0));
    nt_step(5'h1f, nt_exp(SIG_SN3, 1'h1, INFO_4, 1'h1));
    nt_step(5'h17, nt_exp(SIG_SN3, 1'h0, INFO_2, 1'h0));
    nt_step(5'h1f, nt_exp(SIG_SN3, 1'h1, INFO_4, 1'h1));
    nt_step(5'h07, nt_exp(SIG_SN0, 1'h0, INFO_0, 1'h0));
    give_verdict();
  end
endmodule
bind brla_top brla_checker #(.TN_CYCLES(TN_CYCLES)) u_chk (.i_clk,
  .i_rst_n, .i_mf_start, .i_bit_lock, .i_frame_sync, .i_mf_marker,
  .i_ec_conv, .i_eq_conv, .i_rx_act, .i_bd_slot, .o_line_bd, .o_lt_act,
  .i_power, .o_nt_line_sig, .o_nt_line_act, .o_nt_te_info, .o_nt_transp);
